// ==== logic/lpf_regs.svh ====
// Purpose: bit positions and counts of the led pwm function-control block
// Assumes: included by bare name from the package file; the core module has no include of its own
// Notes:   definitions only
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH

`define LPF_SR_W        288
`define LPF_GS_W        12
`define LPF_CH_N        24
`define LPF_GRP_N       3
`define LPF_GRP_CH      8
`define LPF_CFG_W       199
`define LPF_UD_W        17
`define LPF_FC_W        7
`define LPF_RSV_W       23

`define LPF_DC_LO       0
`define LPF_DC_HI       167
`define LPF_BC_LO       168
`define LPF_BC_HI       191
`define LPF_FC_LO       192
`define LPF_FC_HI       198
`define LPF_UD_LO       199
`define LPF_UD_HI       215
`define LPF_TEF_BIT     239
`define LPF_LSD_LO      240
`define LPF_LOD_LO      264

`define LPF_FC_RANGE_LO 0
`define LPF_FC_RANGE_HI 2
`define LPF_FC_REPEAT   3
`define LPF_FC_DTR      4
`define LPF_FC_MODE_LO  5
`define LPF_FC_MODE_HI  6

`define LPF_LAST_12     12'h0fff
`define LPF_LAST_10     12'h03ff
`define LPF_LAST_8      12'h00ff
`define LPF_CNT_ZERO    12'h0000
`define LPF_CNT_ONE     12'h0001
`define LPF_RSV_ZERO    23'h00_0000

`endif

// ==== logic/lpf_pkg.sv ====
// Purpose: types shared by the led pwm function-control block
// Assumes: lpf_regs.svh on the include path
// Notes:   one state struct per clock domain
`include "lpf_regs.svh"

package lpf_pkg;

  typedef enum logic [1:0] {
    LPF_MODE_12,
    LPF_MODE_10,
    LPF_MODE_8
  } lpf_mode_t;

  // system clock domain
  typedef struct packed {
    logic                                    strobe_s1;
    logic                                    strobe_s2;
    logic                                    strobe_prev;
    logic                                    blank_s1;
    logic                                    blank_s2;
    logic [`LPF_GRP_N-1:0]                   gck_s1;
    logic [`LPF_GRP_N-1:0]                   gck_s2;
    logic [`LPF_GRP_N-1:0]                   gck_prev;
    logic [`LPF_CH_N-1:0]                    lod_s1;
    logic [`LPF_CH_N-1:0]                    lod_s2;
    logic [`LPF_CH_N-1:0]                    lsd_s1;
    logic [`LPF_CH_N-1:0]                    lsd_s2;
    logic                                    tef_s1;
    logic                                    tef_s2;
    logic [`LPF_SR_W-1:0]                    gs_latch;
    logic [`LPF_CFG_W-1:0]                   cfg;
    logic [`LPF_UD_W-1:0]                    ud;
    logic [`LPF_SR_W-1:0]                    status;
    logic                                    stat_pend;
    logic                                    stat_req;
    logic [`LPF_GRP_N-1:0][`LPF_GS_W-1:0]    cnt;
    logic [`LPF_GRP_N-1:0]                   run;
    logic [`LPF_GRP_N-1:0]                   done;
    logic [`LPF_CH_N-1:0]                    led;
  } lpf_core_t;

  // serial link clock domain
  typedef struct packed {
    logic [`LPF_SR_W-1:0] sr;
    logic                 out;
    logic                 sel;
    logic                 ack;
  } lpf_link_t;

endpackage

// ==== logic/lpf_core.sv ====
// Purpose: function control, pwm counters, data latches and status readback
// Assumes: clk 10 MHz; group pwm clocks well below clk/3; link clock idle at strobe
// Notes:   two domains, clk and pwm_serial_clock
//
// Behaviour
// - seven-bit function control latch selects range, counter mode, repeat, timing reset
// - bit 192 picks red trim range, 0 low, 1 high
// - bit 193 picks green trim range, 0 low, 1 high
// - bit 194 picks blue trim range, 0 low, 1 high
// - repeat off: each output turns on and off once after blank release
// - repeat on: cycle restarts every 4096, 1024 or 256 group clocks
// - timing reset on: grayscale strobe clears counters and forces outputs off
// - after timing reset pwm resumes at next group clock rising edge
// - timing reset off: strobe leaves counters and outputs alone
// - bits 198,197 pick mode: 0x twelve, 10 ten, 11 eight bit
// - longest on-time 4095, 1023 or 255 group clocks by mode
// - grayscale latch stays 288 bits, twelve per channel, every mode
// - eight and ten bit modes force off at 256th, 1024th clock
// - seventeen-bit user field at bits 215-199, no device effect
// - user field carries messages between the two controllers
// - user field is cleared to zero by reset
// - 288-bit status word: open, short, overtemp flags and setting latches
// - strobe copies shift register to latch, then loads status word
// - after strobe status shifts out one bit per serial clock rising edge
// - strobe level at last serial edge picks grayscale or settings latch
// - blank low holds every output off
// - status bit 239 overtemp, 263-240 short, 287-264 open, bit 240+k or 264+k for channel k
`timescale 1ns/1ps

module lpf_core (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  pwm_serial_clock,
  input  wire logic                  pwm_serial_in,
  output logic                       pwm_serial_out,
  input  wire logic                  latch_strobe,
  input  wire logic                  blank_n,
  input  wire logic [`LPF_GRP_N-1:0] group_pwm_clock,
  input  wire logic [`LPF_CH_N-1:0]  open_led_flag,
  input  wire logic [`LPF_CH_N-1:0]  short_led_flag,
  input  wire logic                  overtemp_flag,
  output logic [`LPF_CH_N-1:0]       led_on,
  output logic [`LPF_GRP_N-1:0]      trim_range_high,
  output logic [`LPF_DC_HI:0]        channel_current_trim,
  output logic [`LPF_BC_HI-`LPF_BC_LO:0] group_brightness
);

  lpf_pkg::lpf_core_t c_q;
  lpf_pkg::lpf_core_t c_d;
  lpf_pkg::lpf_link_t l_q;
  lpf_pkg::lpf_link_t l_d;

  function automatic lpf_pkg::lpf_mode_t mode_of(input logic [1:0] bits);
    lpf_pkg::lpf_mode_t m;
    if (!bits[1]) begin
      m = lpf_pkg::LPF_MODE_12;
    end else if (!bits[0]) begin
      m = lpf_pkg::LPF_MODE_10;
    end else begin
      m = lpf_pkg::LPF_MODE_8;
    end
    return m;
  endfunction

  function automatic logic [`LPF_GS_W-1:0] last_of(input lpf_pkg::lpf_mode_t m);
    logic [`LPF_GS_W-1:0] v;
    unique case (m)
      lpf_pkg::LPF_MODE_12: v = `LPF_LAST_12;
      lpf_pkg::LPF_MODE_10: v = `LPF_LAST_10;
      lpf_pkg::LPF_MODE_8:  v = `LPF_LAST_8;
    endcase
    return v;
  endfunction

  // latch keeps twelve bits; narrow modes only clip the on-time
  function automatic logic [`LPF_GS_W-1:0] clip(input logic [`LPF_GS_W-1:0] lvl,
                                                input logic [`LPF_GS_W-1:0] last);
    return (lvl < last) ? lvl : last;
  endfunction

  // link domain: shift register, strobe target sample, status load
  // status word and request stay still while the link clock idles after a strobe,
  // so they are read here as settled words, the request acting as handshake
  always_comb begin
    l_d     = l_q;
    l_d.sel = latch_strobe;
    // ack follows the request on every edge, so an unknown power-up ack clears itself
    l_d.ack = c_q.stat_req;
    if (c_q.stat_req != l_q.ack) begin
      l_d.out = c_q.status[`LPF_SR_W-1];
      l_d.sr  = {c_q.status[`LPF_SR_W-2:0], pwm_serial_in};
    end else begin
      l_d.out = l_q.sr[`LPF_SR_W-1];
      l_d.sr  = {l_q.sr[`LPF_SR_W-2:0], pwm_serial_in};
    end
  end

  // no reset here: the link clock may be stopped; contents start random
  always_ff @(posedge pwm_serial_clock) begin
    l_q <= l_d;
  end

  // system domain
  always_comb begin
    logic                 commit;
    logic                 dtr_hit;
    logic                 repeat_on;
    logic [`LPF_FC_W-1:0] fc;
    logic [`LPF_GS_W-1:0] last;
    logic [`LPF_GS_W-1:0] lvl;
    int                   g;
    int                   n;
    commit    = 1'b0;
    dtr_hit   = 1'b0;
    repeat_on = 1'b0;
    fc        = '0;
    last      = `LPF_CNT_ZERO;
    lvl       = `LPF_CNT_ZERO;
    c_d       = c_q;

    c_d.strobe_s1   = latch_strobe;
    c_d.strobe_s2   = c_q.strobe_s1;
    c_d.strobe_prev = c_q.strobe_s2;
    c_d.blank_s1    = blank_n;
    c_d.blank_s2    = c_q.blank_s1;
    c_d.gck_s1      = group_pwm_clock;
    c_d.gck_s2      = c_q.gck_s1;
    c_d.gck_prev    = c_q.gck_s2;
    c_d.lod_s1      = open_led_flag;
    c_d.lod_s2      = c_q.lod_s1;
    c_d.lsd_s1      = short_led_flag;
    c_d.lsd_s2      = c_q.lsd_s1;
    c_d.tef_s1      = overtemp_flag;
    c_d.tef_s2      = c_q.tef_s1;

    fc        = c_q.cfg[`LPF_FC_HI:`LPF_FC_LO];
    repeat_on = fc[`LPF_FC_REPEAT];
    last      = last_of(mode_of(fc[`LPF_FC_MODE_HI:`LPF_FC_MODE_LO]));
    commit    = c_q.strobe_s2 && !c_q.strobe_prev;

    // commit first, status load the cycle after so it shows the new latch
    if (commit) begin
      if (l_q.sel) begin
        c_d.cfg = l_q.sr[`LPF_CFG_W-1:0];
        c_d.ud  = l_q.sr[`LPF_UD_HI:`LPF_UD_LO];
      end else begin
        c_d.gs_latch = l_q.sr;
        dtr_hit      = fc[`LPF_FC_DTR];
      end
      c_d.stat_pend = 1'b1;
    end
    if (c_q.stat_pend) begin
      c_d.status    = {c_q.lod_s2, c_q.lsd_s2, c_q.tef_s2, `LPF_RSV_ZERO,
                       c_q.ud, c_q.cfg};
      c_d.stat_pend = 1'b0;
      c_d.stat_req  = !c_q.stat_req;
    end

    for (g = 0; g < `LPF_GRP_N; g++) begin
      if (!c_q.blank_s2 || dtr_hit) begin
        c_d.run[g]  = 1'b0;
        c_d.done[g] = 1'b0;
        c_d.cnt[g]  = `LPF_CNT_ZERO;
      end else if (c_q.gck_s2[g] && !c_q.gck_prev[g]) begin
        if (!c_q.run[g] && !c_q.done[g]) begin
          c_d.run[g] = 1'b1;
          c_d.cnt[g] = `LPF_CNT_ZERO;
        end else if (c_q.run[g]) begin
          if (c_q.cnt[g] == last) begin
            if (repeat_on) begin
              c_d.cnt[g] = `LPF_CNT_ZERO;
            end else begin
              c_d.run[g]  = 1'b0;
              c_d.done[g] = 1'b1;
            end
          end else begin
            c_d.cnt[g] = c_q.cnt[g] + `LPF_CNT_ONE;
          end
        end
      end
    end

    // channel k = 3*n + g, interleaved red, green, blue
    for (n = 0; n < `LPF_GRP_CH; n++) begin
      for (g = 0; g < `LPF_GRP_N; g++) begin
        lvl = clip(c_q.gs_latch[(n*`LPF_GRP_N+g)*`LPF_GS_W +: `LPF_GS_W], last);
        c_d.led[n*`LPF_GRP_N+g] = c_q.blank_s2 && c_d.run[g]
                                  && (c_d.cnt[g] < lvl);
      end
    end
  end

  // latches cleared by reset; software must still load them before use
  always_ff @(posedge clk) begin
    if (reset) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign pwm_serial_out       = l_q.out;
  assign led_on               = c_q.led;
  assign trim_range_high      = c_q.cfg[`LPF_FC_LO+`LPF_FC_RANGE_HI:
                                        `LPF_FC_LO+`LPF_FC_RANGE_LO];
  assign channel_current_trim = c_q.cfg[`LPF_DC_HI:`LPF_DC_LO];
  assign group_brightness     = c_q.cfg[`LPF_BC_HI:`LPF_BC_LO];

endmodule

// ==== testbench/lpf_core_asserts.sv ====
// Purpose: port checks on lpf_core
// Assumes: input syncs take about 3 clk
// Notes:   strobe held 8 clk by the bench
`timescale 1ns/1ps
module lpf_core_asserts (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         pwm_serial_clock,
  input wire logic         latch_strobe,
  input wire logic         blank_n,
  input wire logic [2:0]   group_pwm_clock,
  input wire logic [23:0]  led_on,
  input wire logic [2:0]   trim_range_high,
  input wire logic [167:0] channel_current_trim,
  input wire logic [23:0]  group_brightness
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_blank_hold: assert property (!blank_n [*4] |=> led_on == '0)
    else $error("led on in blank");
  chk_blank_fall: assert property ($fell(blank_n) |-> ##[1:6] led_on == '0)
    else $error("led not off after blank");
  chk_trim_strobe: assert property ($changed(trim_range_high) |-> $past(latch_strobe, 2))
    else $error("trim moved without strobe");
  chk_set_quiet: assert property (!latch_strobe [*6] |=> $stable(channel_current_trim)
    && $stable(group_brightness)) else $error("settings moved while idle");
  chk_bright_load: assert property ($changed(group_brightness) |->
    $past(latch_strobe, 3) && latch_strobe) else $error("brightness moved late");
  chk_on_blank: assert property ($rose(|led_on) |-> $past(blank_n, 3))
    else $error("led on before release");
  chk_on_clock: assert property ($rose(led_on[0]) |-> $past(group_pwm_clock[0], 3))
    else $error("red led on without clock");
  chk_off_cause: assert property ($fell(led_on[0]) && blank_n |->
    $past(group_pwm_clock[0], 3) || $past(latch_strobe, 3)) else $error("red led off early");
  cover property ($rose(led_on[0]));
  cover property ($fell(led_on[0]) && blank_n);
  cover property ($changed(trim_range_high));
endmodule
bind lpf_core lpf_core_asserts u_lpf_core_asserts (.*);

// ==== testbench/lpf_ctl_model.sv ====
// Purpose: display controller model
// Assumes: frames start at a clk fall
// Notes:   link clock idle between frames
`timescale 1ns/1ps
module lpf_ctl_model (
  input  wire logic  clk,
  input  wire logic  pwm_serial_out,
  output logic       pwm_serial_clock,
  output logic       pwm_serial_in,
  output logic       latch_strobe,
  output logic       blank_n,
  output logic [2:0] group_pwm_clock
);
  // blank low keeps outputs off until loaded
  initial {pwm_serial_clock, pwm_serial_in, latch_strobe, blank_n, group_pwm_clock} = '0;
  task automatic frame(input logic [287:0] w, input logic sel, output logic [287:0] rd);
    @(negedge clk);
    #7;
    for (int i = 287; i >= 0; i--) begin
      pwm_serial_in = w[i];
      latch_strobe = sel && i == 0;
      #6 pwm_serial_clock = 1'b1;
      #3 latch_strobe = 1'b0;
      #3 pwm_serial_clock = 1'b0;
      rd = {rd[286:0], pwm_serial_out};
    end
    // released line must not keep its last value
    pwm_serial_in = ~pwm_serial_in;
    @(negedge clk);
    #200 latch_strobe = 1'b1;
    #800 latch_strobe = 1'b0;
    #400;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk) group_pwm_clock = 3'h7;
      #400 group_pwm_clock = 3'h0;
      #200;
    end
    #400;
  endtask
  task automatic set_blank(input logic v);
    @(negedge clk) blank_n = v;
    #400;
  endtask
endmodule

// ==== testbench/test_led_pwm_function_control.sv ====
// Purpose: self-checking bench for lpf_core
// Assumes: model drives serial side and pwm clocks
// Notes:   full-length counts, about 35k clk
`timescale 1ns/1ps
module test_led_pwm_function_control;
  logic         clk = 1'b0;
  logic         reset, overtemp_flag, pwm_serial_clock, pwm_serial_in;
  logic         pwm_serial_out, latch_strobe, blank_n;
  logic [2:0]   group_pwm_clock, trim_range_high;
  logic [23:0]  open_led_flag, short_led_flag, led_on, group_brightness;
  logic [167:0] channel_current_trim;
  logic [287:0] rd, w;
  logic [1:0]   md [3] = '{2'b11, 2'b10, 2'b00};
  int           last [3] = '{255, 1023, 4095};
  int           n_mismatch = 0;
  int           compares = 0;
  lpf_core u_lpf_core (.*);
  lpf_ctl_model u_lpf_ctl_model (.*);
  initial forever #50 clk = ~clk;
  function automatic logic [287:0] st(input logic [6:0] fc);
    return {72'h0, 17'h1_2345, fc, 24'hc3_a596, {21{8'h5a}}};
  endfunction
  task automatic chk(input string nm, input logic [287:0] e, input logic [287:0] g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pwm(input int n, input logic [23:0] e);
    u_lpf_ctl_model.pulse(n);
    chk("led_on", e, led_on);
  endtask
  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    overtemp_flag = 1'b1;
    open_led_flag = 24'h00_00a5;
    short_led_flag = 24'h3c_005a;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    w = st(7'h05);
    u_lpf_ctl_model.frame(w, 1'b1, rd);
    chk("trim", 3'b101, trim_range_high);
    chk("bright", w[191:168], group_brightness);
    chk("dc", w[167:0], channel_current_trim);
    u_lpf_ctl_model.frame(288'h2, 1'b0, rd);
    u_lpf_ctl_model.frame(288'h2, 1'b0, rd);
    chk("status", {open_led_flag, short_led_flag, 24'h80_0000, w[215:0]}, rd);
    u_lpf_ctl_model.set_blank(1'b1);
    pwm(2, 24'h1);
    pwm(2, 24'h0);
    $display("test load and single period done");
    for (int m = 0; m < 3; m++) begin
      u_lpf_ctl_model.set_blank(1'b0);
      u_lpf_ctl_model.frame(st({md[m], 5'h08}), 1'b1, rd);
      u_lpf_ctl_model.frame(288'hfff, 1'b0, rd);
      u_lpf_ctl_model.set_blank(1'b1);
      pwm(last[m], 24'h1);
      pwm(1, 24'h0);
      pwm(1, 24'h1);
    end
    $display("test counter modes done");
    for (int d = 0; d < 2; d++) begin
      u_lpf_ctl_model.set_blank(1'b0);
      u_lpf_ctl_model.frame(st({2'b11, d[0], 4'h2}), 1'b1, rd);
      chk("trim", 3'b010, trim_range_high);
      u_lpf_ctl_model.frame(288'hfff, 1'b0, rd);
      u_lpf_ctl_model.set_blank(1'b1);
      pwm(3, 24'h1);
      u_lpf_ctl_model.frame(288'hfff, 1'b0, rd);
      chk("led_on", {23'h0, ~d[0]}, led_on);
      pwm(1, 24'h1);
    end
    $display("test timing reset done");
    conclude();
  end
  initial begin
    #9_000_000 n_mismatch++;
    conclude();
  end
endmodule
